// file: design/twc_map.vh
// register indices, field positions, reset values and encodings of the timer control block
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
// register indices; byte address is four times the index
`define TWC_IDX_ENABLE_CTRL 6'h00
`define TWC_IDX_WAVE_CTRL 6'h01
`define TWC_IDX_OUT_FORCE 6'h02
`define TWC_IDX_SPLIT 6'h03
`define TWC_IDX_CMD_CLR 6'h04
`define TWC_IDX_CMD_SET 6'h05
`define TWC_IDX_BV_CLR 6'h06
`define TWC_IDX_BV_SET 6'h07
`define TWC_IDX_COUNT 6'h20
`define TWC_IDX_PERIOD 6'h26
`define TWC_IDX_COMPARE_ZERO_VALUE 6'h28
`define TWC_IDX_CMP1 6'h2a
`define TWC_IDX_CMP2 6'h2c
`define TWC_IDX_PERIOD_BUFFER 6'h36
`define TWC_IDX_CMP0BUF 6'h38
`define TWC_IDX_CMP1BUF 6'h3a
`define TWC_IDX_CMP2BUF 6'h3c
// wave control fields
`define TWC_WAVE_MODE_LSB 0
`define TWC_WAVE_AUTO_LOCK_UPDATE_BIT 3
`define TWC_WAVE_CHEN_LSB 4
// command register fields
`define TWC_CMD_DIR_BIT 0
`define TWC_CMD_LOCK_UPDATE_BIT 1
`define TWC_CMD_CMD_LSB 2
// buffer valid fields
`define TWC_BV_PER_BIT 0
`define TWC_BV_CMP_LSB 1
// waveform modes
`define TWC_MODE_NORMAL 3'h0
`define TWC_MODE_FRQ 3'h1
`define TWC_MODE_SINGLE 3'h3
`define TWC_MODE_DS_TOP 3'h5
`define TWC_MODE_DS_BOTH 3'h6
`define TWC_MODE_DS_BOTTOM 3'h7
// commands
`define TWC_CMD_NONE 2'h0
`define TWC_CMD_UPDATE 2'h1
`define TWC_CMD_RESTART 2'h2
`define TWC_CMD_HARD_RESET 2'h3
// reset values
`define TWC_RST_CTRL8 8'h00
`define TWC_RST_TOP16 16'hffff
`define TWC_RST_ZERO16 16'h0000
`endif

// file: design/twc_timer_ctrl.v
// timer waveform control: apb registers, mode decode, buffered update and waveform outputs
`timescale 1ns/1ps
`include "twc_map.vh"
module twc_timer_ctrl #(
   parameter CW = 16,
   parameter NCH = 3
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   output reg [NCH-1:0] waveform_output_pin_out,
   output reg [NCH-1:0] pin_override_out,
   output reg overflow_event_out,
   output reg update_event_out,
   output reg split_enable_out
);

   // one wait state: data and error are registered on the same edge that pready rises
   wire access = psel_in & penable_in;
   wire commit = access & pready_out;
   wire wr = commit & pwrite_in;
   wire [5:0] idx = paddr_in[7:2];

   function mapped;
      input [7:0] a;
      begin
         case (a[7:2])
            `TWC_IDX_ENABLE_CTRL, `TWC_IDX_WAVE_CTRL, `TWC_IDX_OUT_FORCE, `TWC_IDX_SPLIT,
            `TWC_IDX_CMD_CLR, `TWC_IDX_CMD_SET, `TWC_IDX_BV_CLR, `TWC_IDX_BV_SET,
            `TWC_IDX_COUNT, `TWC_IDX_PERIOD, `TWC_IDX_COMPARE_ZERO_VALUE, `TWC_IDX_CMP1, `TWC_IDX_CMP2,
            `TWC_IDX_PERIOD_BUFFER, `TWC_IDX_CMP0BUF, `TWC_IDX_CMP1BUF,
            `TWC_IDX_CMP2BUF: mapped = (a[1:0] == 2'h0);
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   // one-hot write strobe per register index; a wire so every reader sees it change
   wire [63:0] hit = (wr & (paddr_in[1:0] == 2'h0)) ? (64'h1 << idx) : 64'h0;

   reg enable_q;
   reg [2:0] wave_mode_q;
   reg auto_lock_q;
   reg [NCH-1:0] ch_en_q;
   reg [NCH-1:0] force_q;
   reg split_q;
   reg lock_update_q, lock_update_d;
   reg dir_q, dir_d;
   reg per_bv_q, per_bv_d;
   reg [NCH-1:0] cmp_bv_q, cmp_bv_d;
   reg [CW-1:0] cnt_q, cnt_d;
   reg [CW-1:0] per_q, per_d;
   reg [CW-1:0] period_buffer_q;
   reg [CW-1:0] cmp_q [0:NCH-1];
   reg [CW-1:0] cmpbuf_q [0:NCH-1];
   reg [NCH-1:0] wg_q, wg_d;
   reg ovf_d, upd_d;

   wire wr_clr = hit[`TWC_IDX_CMD_CLR];
   wire wr_set = hit[`TWC_IDX_CMD_SET];
   // split flag follows a write at once so the datapath switches maps without delay
   wire split_d_w = hit[`TWC_IDX_SPLIT] ? pwdata_in[0] : split_q;
   wire [1:0] cmd = (wr_clr | wr_set) ? pwdata_in[`TWC_CMD_CMD_LSB +: 2] : `TWC_CMD_NONE;
   wire hard_rst = (cmd == `TWC_CMD_HARD_RESET) & ~enable_q;
   wire restart = (cmd == `TWC_CMD_RESTART);
   wire force_upd = (cmd == `TWC_CMD_UPDATE);

   // mode decode; reserved codes fall through to plain counting
   wire m_frq = (wave_mode_q == `TWC_MODE_FRQ);
   wire m_ss = (wave_mode_q == `TWC_MODE_SINGLE);
   wire m_ds = (wave_mode_q == `TWC_MODE_DS_TOP) | (wave_mode_q == `TWC_MODE_DS_BOTH) |
               (wave_mode_q == `TWC_MODE_DS_BOTTOM);
   wire m_wave = m_frq | m_ss | m_ds;
   wire [CW-1:0] top = m_frq ? cmp_q[0] : per_q;
   wire at_top = (cnt_q >= top);
   wire at_bot = (cnt_q == {CW{1'b0}});

   // counter, events and direction
   always @* begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      ovf_d = 1'b0;
      upd_d = 1'b0;
      if (enable_q) begin
         if (m_ds) begin
            if (~dir_q & at_top) begin
               dir_d = 1'b1;
               cnt_d = cnt_q - 1'b1;
               ovf_d = (wave_mode_q != `TWC_MODE_DS_BOTTOM);
            end else if (dir_q & at_bot) begin
               dir_d = 1'b0;
               cnt_d = cnt_q + 1'b1;
               upd_d = 1'b1;
               ovf_d = (wave_mode_q != `TWC_MODE_DS_TOP);
            end else begin
               cnt_d = dir_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
            end
         end else if (~dir_q) begin
            // up: wrap at TOP; single slope reports the event as BOTTOM is entered
            if (at_top) begin
               cnt_d = {CW{1'b0}};
               upd_d = 1'b1;
               ovf_d = 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end else begin
            if (at_bot) begin
               cnt_d = top;
               upd_d = 1'b1;
               ovf_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
      end
      if (restart) begin
         cnt_d = {CW{1'b0}};
         dir_d = 1'b0;
      end
      // software direction writes win over hardware steering
      if (wr_clr & pwdata_in[`TWC_CMD_DIR_BIT]) dir_d = 1'b0;
      if (wr_set & pwdata_in[`TWC_CMD_DIR_BIT]) dir_d = 1'b1;
      if (force_upd) upd_d = 1'b1;
   end

   wire xfer = upd_d & ~lock_update_q;

   // buffer valid flags and lock
   always @* begin
      per_bv_d = per_bv_q;
      cmp_bv_d = cmp_bv_q;
      lock_update_d = lock_update_q;
      per_d = per_q;
      if (xfer) begin
         per_bv_d = 1'b0;
         cmp_bv_d = {NCH{1'b0}};
         if (per_bv_q) per_d = period_buffer_q;
      end
      if (hit[`TWC_IDX_BV_CLR]) begin
         per_bv_d = per_bv_d & ~pwdata_in[`TWC_BV_PER_BIT];
         cmp_bv_d = cmp_bv_d & ~pwdata_in[`TWC_BV_CMP_LSB +: NCH];
      end
      if (hit[`TWC_IDX_BV_SET]) begin
         per_bv_d = per_bv_d | pwdata_in[`TWC_BV_PER_BIT];
         cmp_bv_d = cmp_bv_d | pwdata_in[`TWC_BV_CMP_LSB +: NCH];
      end
      // buffer writes placed last so a set wins over a same-cycle clear
      if (hit[`TWC_IDX_PERIOD_BUFFER]) per_bv_d = 1'b1;
      if (hit[`TWC_IDX_CMP0BUF]) cmp_bv_d[0] = 1'b1;
      if (hit[`TWC_IDX_CMP1BUF]) cmp_bv_d[1] = 1'b1;
      if (hit[`TWC_IDX_CMP2BUF]) cmp_bv_d[2] = 1'b1;
      if (hit[`TWC_IDX_PERIOD]) per_d = pwdata_in[CW-1:0];
      if (auto_lock_q) begin
         if (xfer) lock_update_d = 1'b1;
         else if ((cmp_bv_q & ch_en_q) == ch_en_q) lock_update_d = 1'b0;
      end
      if (wr_clr & pwdata_in[`TWC_CMD_LOCK_UPDATE_BIT]) lock_update_d = 1'b0;
      if (wr_set & pwdata_in[`TWC_CMD_LOCK_UPDATE_BIT]) lock_update_d = 1'b1;
   end

   // waveform generator levels
   integer k;
   always @* begin
      wg_d = wg_q;
      if (~enable_q) begin
         if (hit[`TWC_IDX_OUT_FORCE]) wg_d = pwdata_in[NCH-1:0];
      end else if (m_frq) begin
         if (upd_d) wg_d[0] = ~wg_q[0];
      end else if (m_ss | m_ds) begin
         for (k = 0; k < NCH; k = k + 1) begin
            wg_d[k] = (cnt_d < cmp_q[k]);
         end
      end
   end

   // register file and state
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gch
         always @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               cmp_q[g] <= `TWC_RST_ZERO16;
               cmpbuf_q[g] <= `TWC_RST_ZERO16;
            end else if (hard_rst) begin
               cmp_q[g] <= `TWC_RST_ZERO16;
               cmpbuf_q[g] <= `TWC_RST_ZERO16;
            end else begin
               if (hit[`TWC_IDX_COMPARE_ZERO_VALUE + 2 * g]) cmp_q[g] <= pwdata_in[CW-1:0];
               else if (xfer & cmp_bv_q[g]) cmp_q[g] <= cmpbuf_q[g];
               if (hit[`TWC_IDX_CMP0BUF + 2 * g]) cmpbuf_q[g] <= pwdata_in[CW-1:0];
            end
         end
      end
   endgenerate

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable_q <= 1'b0;
         wave_mode_q <= 3'h0;
         auto_lock_q <= 1'b0;
         ch_en_q <= {NCH{1'b0}};
         force_q <= {NCH{1'b0}};
         split_q <= 1'b0;
         lock_update_q <= 1'b0;
         dir_q <= 1'b0;
         per_bv_q <= 1'b0;
         cmp_bv_q <= {NCH{1'b0}};
         cnt_q <= `TWC_RST_ZERO16;
         per_q <= `TWC_RST_TOP16;
         period_buffer_q <= `TWC_RST_ZERO16;
         wg_q <= {NCH{1'b0}};
      end else if (hard_rst) begin
         // hard reset returns the counter state, period, compare and buffer registers but keeps control configuration
         lock_update_q <= 1'b0;
         dir_q <= 1'b0;
         per_bv_q <= 1'b0;
         cmp_bv_q <= {NCH{1'b0}};
         cnt_q <= `TWC_RST_ZERO16;
         per_q <= `TWC_RST_TOP16;
         period_buffer_q <= `TWC_RST_ZERO16;
         wg_q <= {NCH{1'b0}};
      end else begin
         if (hit[`TWC_IDX_ENABLE_CTRL]) enable_q <= pwdata_in[0];
         if (hit[`TWC_IDX_WAVE_CTRL]) begin
            wave_mode_q <= pwdata_in[`TWC_WAVE_MODE_LSB +: 3];
            auto_lock_q <= pwdata_in[`TWC_WAVE_AUTO_LOCK_UPDATE_BIT];
            ch_en_q <= pwdata_in[`TWC_WAVE_CHEN_LSB +: NCH];
         end
         if (hit[`TWC_IDX_OUT_FORCE]) force_q <= pwdata_in[NCH-1:0];
         if (hit[`TWC_IDX_SPLIT]) split_q <= pwdata_in[0];
         if (hit[`TWC_IDX_PERIOD_BUFFER]) period_buffer_q <= pwdata_in[CW-1:0];
         if (hit[`TWC_IDX_COUNT]) cnt_q <= pwdata_in[CW-1:0];
         else cnt_q <= cnt_d;
         lock_update_q <= lock_update_d;
         dir_q <= dir_d;
         per_bv_q <= per_bv_d;
         cmp_bv_q <= cmp_bv_d;
         per_q <= per_d;
         wg_q <= wg_d;
      end
   end

   // read mux; command bits never stored so they read zero
   reg [31:0] rd;
   always @* begin
      rd = 32'h0000_0000;
      case (idx)
         `TWC_IDX_ENABLE_CTRL: rd[0] = enable_q;
         `TWC_IDX_WAVE_CTRL: rd[7:0] = {1'b0, ch_en_q, auto_lock_q, wave_mode_q};
         `TWC_IDX_OUT_FORCE: rd[NCH-1:0] = force_q;
         `TWC_IDX_SPLIT: rd[0] = split_q;
         `TWC_IDX_CMD_CLR, `TWC_IDX_CMD_SET: rd[1:0] = {lock_update_q, dir_q};
         `TWC_IDX_BV_CLR, `TWC_IDX_BV_SET: rd[3:0] = {cmp_bv_q, per_bv_q};
         `TWC_IDX_COUNT: rd[CW-1:0] = cnt_q;
         `TWC_IDX_PERIOD: rd[CW-1:0] = per_q;
         `TWC_IDX_COMPARE_ZERO_VALUE: rd[CW-1:0] = cmp_q[0];
         `TWC_IDX_CMP1: rd[CW-1:0] = cmp_q[1];
         `TWC_IDX_CMP2: rd[CW-1:0] = cmp_q[2];
         `TWC_IDX_PERIOD_BUFFER: rd[CW-1:0] = period_buffer_q;
         `TWC_IDX_CMP0BUF: rd[CW-1:0] = cmpbuf_q[0];
         `TWC_IDX_CMP1BUF: rd[CW-1:0] = cmpbuf_q[1];
         `TWC_IDX_CMP2BUF: rd[CW-1:0] = cmpbuf_q[2];
         default: rd = 32'h0000_0000;
      endcase
      if (!mapped(paddr_in)) rd = 32'h0000_0000;
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
         waveform_output_pin_out <= {NCH{1'b0}};
         pin_override_out <= {NCH{1'b0}};
         overflow_event_out <= 1'b0;
         update_event_out <= 1'b0;
         split_enable_out <= 1'b0;
      end else begin
         pready_out <= access & ~pready_out;
         prdata_out <= (access & ~pready_out & ~pwrite_in) ? rd : 32'h0000_0000;
         pslverr_out <= access & ~pready_out & ~mapped(paddr_in);
         // pins see the level only for enabled channels in waveform modes
         waveform_output_pin_out <= wg_d & ch_en_q & {NCH{m_wave}};
         pin_override_out <= ch_en_q & {NCH{m_wave}};
         overflow_event_out <= ovf_d;
         update_event_out <= upd_d;
         split_enable_out <= split_d_w;
      end
   end

endmodule

// file: test/twc_timer_ctrl_props.sv
// assertions on the apb and waveform ports of the timer control block
`timescale 1ns/1ps
module twc_timer_ctrl_props #(parameter CW = 16, parameter NCH = 3) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire [NCH-1:0] waveform_output_pin_out,
   input wire [NCH-1:0] pin_override_out,
   input wire overflow_event_out,
   input wire update_event_out,
   input wire split_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   wire acc = psel_in && penable_in;
   wire done = acc && pready_out;
   ready_wait_a: assert property (acc && !pready_out |=> pready_out)
      else $error("ready late");
   ready_cause_a: assert property (!acc |=> !pready_out)
      else $error("ready without access");
   ready_once_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   unmapped_err_a: assert property (done && paddr_in[7:2] == 6'h10 |-> pslverr_out)
      else $error("hole not refused");
   cmd_reads_zero_a: assert property (done && !pwrite_in && paddr_in[7:3] == 5'h02 |-> prdata_out[3:2] == 2'h0)
      else $error("command field read nonzero");
   split_follow_a: assert property (done && pwrite_in && paddr_in == 8'h0c |=> split_enable_out == $past(pwdata_in[0]))
      else $error("split bit not taken");
   force_update_a: assert property (done && pwrite_in && paddr_in == 8'h14 && pwdata_in[3:2] == 2'h1 |-> ##[1:3] update_event_out)
      else $error("forced update missing");
   wave_gated_a: assert property ((waveform_output_pin_out & ~pin_override_out) == '0)
      else $error("wave level without enable");
   cover property (done && pslverr_out);
   cover property (overflow_event_out);
   cover property (|pin_override_out);
endmodule

// file: test/twc_pin_model.sv
// port pin model: waveform level overrides the port latch where enabled
`timescale 1ns/1ps
module twc_pin_model (
   input wire [2:0] port_value_in,
   input wire [2:0] wave_in,
   input wire [2:0] override_in,
   output wire [2:0] pin_level_out
);
   assign pin_level_out = (override_in & wave_in) | (~override_in & port_value_in);
endmodule

// file: test/twc_timer_ctrl_tb.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
module twc_timer_ctrl_tb;
   logic clk_sys_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic prdy, perr, ovf, upd, split;
   logic [2:0] wave, ovr, pin, port_val = 0;
   int num_errors = 0, checks = 0, rg[64];
   always #2.5 clk_sys_in = ~clk_sys_in;
   twc_timer_ctrl twc_timer_ctrl_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
      .waveform_output_pin_out(wave), .pin_override_out(ovr), .overflow_event_out(ovf),
      .update_event_out(upd), .split_enable_out(split));
   twc_pin_model twc_pin_model_i (.port_value_in(port_val), .wave_in(wave),
      .override_in(ovr), .pin_level_out(pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one idle cycle after each transfer keeps psel from being driven twice in a step
   task automatic apb(input bit w, input int idx, input int v, output logic [31:0] d,
         output logic e);
      int n = 0;
      psel <= 1;
      pwr <= w;
      paddr <= 8'(idx << 2);
      pwdata <= 32'(v);
      @(posedge clk_sys_in);
      pen <= 1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (prdy !== 1'b1 && n < 50);
      d = prdata;
      e = perr;
      psel <= 0;
      pen <= 0;
      if (n >= 50) num_errors++;
      @(posedge clk_sys_in);
   endtask
   task automatic model_upd;
      if (!rg[4][1]) begin
         if (rg[6][0]) rg['h26] = rg['h36];
         for (int c = 0; c < 3; c++) if (rg[6][c+1]) rg['h28+2*c] = rg['h38+2*c];
         rg[6] = 0;
         if (rg[1][3]) rg[4] |= 2;
      end
   endtask
   task automatic wr(input int idx, input int v);
      logic [31:0] d;
      logic e;
      apb(1, idx, v, d, e);
      case (idx)
         0, 3: rg[idx] = v & 1;
         1: rg[1] = v & 'h7f;
         2: rg[2] = v & 7;
         4: rg[4] &= ~(v & 3);
         5: begin
            rg[4] |= v & 3;
            case ((v >> 2) & 3)
               1: model_upd();
               2: rg[4] &= ~1;
               3: if (!rg[0]) begin
                  rg[4] = 0;
                  rg[6] = 0;
                  for (int a = 'h26; a < 'h3e; a += 2) rg[a] = 0;
                  rg['h26] = 'hffff;
               end
               default: ;
            endcase
         end
         6: rg[6] &= ~(v & 'hf);
         7: rg[6] |= v & 'hf;
         default: begin
            rg[idx] = v & 'hffff;
            if (idx == 'h36) rg[6] |= 1;
            if (idx >= 'h38) rg[6] |= 2 << ((idx - 'h38) / 2);
         end
      endcase
      if (rg[1][3] && ((rg[6] >> 1) & (rg[1] >> 4) & 7) == ((rg[1] >> 4) & 7))
         rg[4] &= ~2;
   endtask
   task automatic rd(input int idx);
      logic [31:0] d;
      logic e;
      bit m = idx < 8 || idx inside {'h20, 'h26, 'h28, 'h2a, 'h2c, 'h36, 'h38, 'h3a, 'h3c};
      int x = (idx == 5 || idx == 7) ? rg[idx-1] : rg[idx];
      apb(0, idx, 0, d, e);
      chk({e, d[30:0]}, {!m, 31'(x)});
   endtask
   task automatic gap(input bit o, output int n);
      int k = 0;
      n = 0;
      while ((o ? ovf : upd) !== 1'b1 && k < 200) begin
         @(posedge clk_sys_in);
         k++;
      end
      do begin
         @(posedge clk_sys_in);
         n++;
      end while ((o ? ovf : upd) !== 1'b1 && n < 200);
   endtask
   initial begin
      int g;
      bit wm;
      logic [2:0] f;
      void'($urandom(32'he3f5121b));
      rg['h26] = 'hffff;
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1;
      @(posedge clk_sys_in);
      for (int i = 0; i < 'h3e; i += (i < 8) ? 1 : 2) rd(i);
      $display("reset values done");
      repeat (4) begin
         wr(5, $urandom & 3);
         rd(4);
         wr(4, $urandom & 3);
         rd(5);
      end
      wr(3, 1);
      chk(split, 1);
      $display("set and clear aliases done");
      wr('h36, $urandom & 'hffff);
      wr('h3a, $urandom & 'hffff);
      rd(6);
      wr(5, 2);
      wr(5, 4);
      rd(6);
      rd('h26);
      wr(4, 2);
      wr(5, 4);
      rd(6);
      rd('h26);
      rd('h2a);
      wr(7, 'hf);
      wr(6, $urandom & 'hf);
      rd(7);
      wr(5, 4);
      rd(6);
      $display("buffer valid done");
      f = 3'($urandom);
      port_val <= 3'($urandom);
      wr(2, f);
      for (int m = 0; m < 8; m++) begin
         wr(1, m | 'h70);
         repeat (2) @(posedge clk_sys_in);
         wm = m inside {1, 3, 5, 6, 7};
         chk(ovr, wm ? 3'h7 : 3'h0);
         chk(wave, wm ? f : 3'h0);
         chk(pin, wm ? f : port_val);
      end
      $display("waveform pins done");
      wr(4, 3);
      wr('h26, 9);
      wr('h28, 5);
      for (int m = 0; m < 8; m++) begin
         if (m == 2 || m == 4) continue;
         wr(1, m);
         wr(0, 1);
         gap(1, g);
         gap(1, g);
         chk(g, m == 1 ? 6 : m == 6 ? 9 : m >= 5 ? 18 : 10);
         gap(0, g);
         gap(0, g);
         chk(g, m == 1 ? 6 : m >= 5 ? 18 : 10);
         wr(0, 0);
         wr(5, 8);
      end
      $display("counter events done");
      wr('h26, 'h1234);
      wr(0, 1);
      wr(5, 'hc);
      rd('h26);
      wr(0, 0);
      wr(5, 'hc);
      rd('h26);
      rd(6);
      $display("hard reset done");
      wr(1, 'h18);
      wr(5, 4);
      rd(4);
      wr('h38, $urandom & 'hffff);
      rd(4);
      $display("auto lock done");
      finish_test();
   end
   initial begin
      #(5 * 40000);
      num_errors++;
      finish_test();
   end
endmodule
bind twc_timer_ctrl twc_timer_ctrl_props #(.CW(CW), .NCH(NCH)) twc_timer_ctrl_props_i (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .waveform_output_pin_out(waveform_output_pin_out), .pin_override_out(pin_override_out),
   .overflow_event_out(overflow_event_out), .update_event_out(update_event_out),
   .split_enable_out(split_enable_out));
